// >>> logic/acl_action_map.vh
// Constants for the ACL action and count unit.
// Assumes a 100 MHz core clock and a seven-port switch.
`ifndef ACL_ACTION_MAP_VH
`define ACL_ACTION_MAP_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define NUM_PORTS 7
`define NUM_ENTRIES 16
`define ENTRY_IDX_W 4
`define COUNT_W 11

// ----------------------------------------------------------------
// Action field layout (count value overlays priority and map bits)
// ----------------------------------------------------------------
`define ACT_W 20
`define ACT_PM_HI 19
`define ACT_PM_LO 18
`define ACT_P_HI 17
`define ACT_P_LO 15
`define ACT_RPE 14
`define ACT_RP_HI 13
`define ACT_RP_LO 11
`define ACT_MM_HI 10
`define ACT_MM_LO 9
`define ACT_FWD_HI 6
`define ACT_FWD_LO 0
`define ACT_CNT_HI 19
`define ACT_CNT_LO 9
`define ACT_TU 8
`define ACT_CA 7

// ----------------------------------------------------------------
// Match mode codes
// ----------------------------------------------------------------
`define MATCH_LAYER_COUNT 2'h1
`define MATCH_VARIANT_COUNT 2'h0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 100
`define US_NS 1000
`define CLK_NS 10
`define US_CYCLES (`US_NS / `CLK_NS)
`define MS_US 1000

`endif

// >>> logic/acl_action_and_count_unit.v
// ACL action stage with count-mode interrupt logic, for all ports.
// Assumes match results, QoS priority and lookup map are synchronous to ref_clk.
`timescale 1ns/1ps
`include "acl_action_map.vh"

module acl_action_and_count_unit (
    // Clock and reset
    input wire ref_clk,
    input wire rst_n,
    // Table write port
    input wire tbl_wr,
    input wire [2:0] tbl_port,
    input wire [`ENTRY_IDX_W-1:0] tbl_idx,
    input wire [1:0] tbl_match_layer_sel,
    input wire [1:0] tbl_match_variant_sel,
    input wire [`ACT_W-1:0] tbl_action,
    input wire [7:0] tbl_process,
    // Packet lookup result
    input wire pkt_valid,
    input wire [2:0] pkt_port,
    input wire pkt_hit,
    input wire [`ENTRY_IDX_W-1:0] pkt_idx,
    input wire [2:0] qos_priority,
    input wire [2:0] vlan_pcp,
    input wire [`NUM_PORTS-1:0] lookup_map,
    // Action result
    output reg res_valid,
    output reg [2:0] res_priority,
    output reg [2:0] res_pcp,
    output reg [`NUM_PORTS-1:0] res_map,
    output reg [7:0] res_process,
    // Interrupt status and masks
    input wire [`NUM_PORTS-1:0] port_int_mask,
    input wire [`NUM_PORTS-1:0] port_int_clear,
    input wire [`NUM_PORTS-1:0] global_int_mask,
    output wire [`NUM_PORTS-1:0] port_int_status,
    output wire [`NUM_PORTS-1:0] global_int_status,
    output wire int_out
);

    // ------------------------------------------------------------
    // Entry tables
    // ------------------------------------------------------------
    localparam TBL_D = `NUM_PORTS * `NUM_ENTRIES;

    reg [`ACT_W-1:0] action_mem [0:TBL_D-1];
    reg [7:0] process_mem [0:TBL_D-1];
    reg [TBL_D-1:0] count_mode_reg;

    function [6:0] slot;
        input [2:0] port;
        input [`ENTRY_IDX_W-1:0] idx;
        begin
            slot = {port, idx};
        end
    endfunction

    function port_valid;
        input [2:0] port;
        begin
            port_valid = (port < `NUM_PORTS);
        end
    endfunction

    function count_code;
        input [1:0] layer;
        input [1:0] variant;
        begin
            count_code = (layer == `MATCH_LAYER_COUNT) && (variant == `MATCH_VARIANT_COUNT);
        end
    endfunction

    // Table storage, one slot per port and entry
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            count_mode_reg <= {TBL_D{1'b0}};
        end else if (tbl_wr && port_valid(tbl_port)) begin
            action_mem[slot(tbl_port, tbl_idx)] <= tbl_action;
            process_mem[slot(tbl_port, tbl_idx)] <= tbl_process;
            count_mode_reg[slot(tbl_port, tbl_idx)] <=
                count_code(tbl_match_layer_sel, tbl_match_variant_sel);
        end
    end

    wire [6:0] pkt_slot = slot(pkt_port, pkt_idx);
    wire port_ok = port_valid(pkt_port);
    wire [`ACT_W-1:0] act = action_mem[pkt_slot];
    wire is_count = count_mode_reg[pkt_slot];
    wire filter_hit = pkt_valid && pkt_hit && port_ok && !is_count;

    // ------------------------------------------------------------
    // Filtering action
    // ------------------------------------------------------------
    wire [1:0] priority_override_sel = act[`ACT_PM_HI:`ACT_PM_LO];
    wire [2:0] rule_priority = act[`ACT_P_HI:`ACT_P_LO];
    wire remark_enable = act[`ACT_RPE];
    wire [2:0] remark_priority_value = act[`ACT_RP_HI:`ACT_RP_LO];
    wire [1:0] map_combine_sel = act[`ACT_MM_HI:`ACT_MM_LO];
    // Bit n is port n
    wire [`NUM_PORTS-1:0] fwd_mask = act[`ACT_FWD_HI:`ACT_FWD_LO];

    // Priority chosen by the override mode
    function [2:0] pick_priority;
        input [1:0] sel;
        input [2:0] rule_prio;
        input [2:0] qos_prio;
        begin
            case (sel)
                2'h0: pick_priority = qos_prio;
                2'h1: pick_priority = (rule_prio > qos_prio) ? rule_prio : qos_prio;
                2'h2: pick_priority = (rule_prio < qos_prio) ? rule_prio : qos_prio;
                default: pick_priority = rule_prio;
            endcase
        end
    endfunction

    // Forwarding map chosen by the combine mode
    function [`NUM_PORTS-1:0] pick_map;
        input [1:0] sel;
        input [`NUM_PORTS-1:0] mask;
        input [`NUM_PORTS-1:0] lookup;
        begin
            case (sel)
                2'h0: pick_map = lookup;
                2'h1: pick_map = lookup | mask;
                2'h2: pick_map = lookup & mask;
                default: pick_map = mask;
            endcase
        end
    endfunction

    reg [2:0] prio_next;
    reg [2:0] pcp_next;
    reg [`NUM_PORTS-1:0] map_next;

    always @* begin
        prio_next = qos_priority;
        pcp_next = vlan_pcp;
        map_next = lookup_map;
        if (filter_hit) begin
            prio_next = pick_priority(priority_override_sel, rule_priority, qos_priority);
            if (remark_enable) begin
                pcp_next = remark_priority_value;
            end
            map_next = pick_map(map_combine_sel, fwd_mask, lookup_map);
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_priority <= 3'h0;
            res_pcp <= 3'h0;
            res_map <= {`NUM_PORTS{1'b0}};
            res_process <= 8'h00;
        end else begin
            res_valid <= pkt_valid;
            res_priority <= prio_next;
            res_pcp <= pcp_next;
            res_map <= map_next;
            res_process <= filter_hit ? process_mem[pkt_slot] : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Tick generation from the core clock
    // ------------------------------------------------------------
    reg [6:0] us_div_reg;
    reg [9:0] ms_div_reg;
    wire us_last = (us_div_reg == `US_CYCLES - 1);
    wire ms_last = (ms_div_reg == `MS_US - 1);
    wire us_tick = us_last;
    wire ms_tick = us_last && ms_last;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            us_div_reg <= 7'h00;
        end else if (us_last) begin
            us_div_reg <= 7'h00;
        end else begin
            us_div_reg <= us_div_reg + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Millisecond divider, advanced by the microsecond pulse
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ms_div_reg <= 10'h000;
        end else if (us_last && ms_last) begin
            ms_div_reg <= 10'h000;
        end else if (us_last) begin
            ms_div_reg <= ms_div_reg + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // Per-port count engines
    // ------------------------------------------------------------
    // One-hot engine states: idle, timed countdown, packet count
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_TIMED = 3'h2;
    localparam [2:0] ST_PKTS = 3'h4;

    reg [`NUM_PORTS-1:0] status_reg;
    wire [`NUM_PORTS-1:0] count_event;

    genvar p;
    generate
        for (p = 0; p < `NUM_PORTS; p = p + 1) begin : g_port
            reg [2:0] state_reg;
            reg [`COUNT_W-1:0] cnt_reg;
            reg unit_reg;
            // Only count entries that matched address and EtherType qualify
            wire qual = pkt_valid && pkt_hit && port_ok && is_count && (pkt_port == p);
            // Count value overlays priority, remark and map bits
            wire [`COUNT_W-1:0] cval = act[`ACT_CNT_HI:`ACT_CNT_LO];
            wire pkt_algo = act[`ACT_CA];
            wire tick = unit_reg ? ms_tick : us_tick;
            // Packet counting starts from zero when entered from another state
            wire [`COUNT_W-1:0] base = (state_reg == ST_PKTS) ? cnt_reg : {`COUNT_W{1'b0}};
            wire expire = (state_reg == ST_TIMED) && !qual && tick &&
                          (cnt_reg == {`COUNT_W{1'b0}});
            wire reach = qual && pkt_algo && (base + 11'h001 >= cval);
            assign count_event[p] = expire || reach;

            always @(posedge ref_clk) begin
                if (!rst_n) begin
                    state_reg <= ST_IDLE;
                    cnt_reg <= {`COUNT_W{1'b0}};
                    unit_reg <= 1'b0;
                end else if (qual) begin
                    unit_reg <= act[`ACT_TU];
                    if (!pkt_algo) begin
                        state_reg <= ST_TIMED;
                        cnt_reg <= cval;
                    end else begin
                        state_reg <= ST_PKTS;
                        cnt_reg <= reach ? {`COUNT_W{1'b0}} : base + 11'h001;
                    end
                end else begin
                    case (state_reg)
                        ST_TIMED: begin
                            if (expire) begin
                                state_reg <= ST_IDLE;
                            end else if (tick) begin
                                cnt_reg <= cnt_reg - 11'h001;
                            end
                        end
                        ST_PKTS: begin
                            state_reg <= ST_PKTS;
                        end
                        ST_IDLE: begin
                            state_reg <= ST_IDLE;
                        end
                        default: begin
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            status_reg <= {`NUM_PORTS{1'b0}};
        end else begin
            // Set wins over clear
            status_reg <= (status_reg & ~port_int_clear) | count_event;
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    assign port_int_status = status_reg;
    assign global_int_status = status_reg & port_int_mask;
    assign int_out = |(global_int_status & global_int_mask);

endmodule

// >>> bench/acl_lookup_model.sv
// Lookup and QoS stand-in: fresh packet fields at each falling edge.
// Assumes the bench samples them just after that edge.
`timescale 1ns/1ps
module acl_lookup_model (
    input wire ref_clk,
    output reg [2:0] qos_priority,
    output reg [2:0] vlan_pcp,
    output reg [6:0] lookup_map
);
    reg [31:0] r;
    integer seed = 76636;
    always @(negedge ref_clk) begin
        r = $random(seed);
        {qos_priority, vlan_pcp, lookup_map} <= r[12:0];
    end
endmodule

// >>> bench/acl_action_props.sv
// Port properties of the ACL action and count unit.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
`include "acl_action_map.vh"
module acl_action_props (
    input wire ref_clk, input wire rst_n, input wire pkt_valid, input wire pkt_hit,
    input wire [2:0] qos_priority, input wire [2:0] vlan_pcp,
    input wire [`NUM_PORTS-1:0] lookup_map, input wire res_valid,
    input wire [2:0] res_priority, input wire [2:0] res_pcp,
    input wire [`NUM_PORTS-1:0] res_map, input wire [7:0] res_process,
    input wire [`NUM_PORTS-1:0] port_int_mask, input wire [`NUM_PORTS-1:0] port_int_clear,
    input wire [`NUM_PORTS-1:0] global_int_mask, input wire [`NUM_PORTS-1:0] port_int_status,
    input wire [`NUM_PORTS-1:0] global_int_status, input wire int_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire miss = pkt_valid && !pkt_hit;
    reg [`NUM_PORTS-1:0] keep_reg;
    always @(posedge ref_clk) keep_reg <= port_int_status & ~port_int_clear;
    valid_follow_a: assert property (pkt_valid |=> res_valid) else $error("no result");
    valid_pulse_a: assert property (!pkt_valid |=> !res_valid) else $error("stray result");
    miss_prio_a: assert property (miss |=> res_priority == $past(qos_priority))
        else $error("priority changed on miss");
    miss_pcp_a: assert property (miss |=> res_pcp == $past(vlan_pcp))
        else $error("pcp changed on miss");
    miss_map_a: assert property (miss |=> res_map == $past(lookup_map))
        else $error("map changed on miss");
    status_sticky_a: assert property ((port_int_status & keep_reg) == keep_reg)
        else $error("status dropped");
    port_gate_a: assert property (global_int_status == (port_int_status & port_int_mask))
        else $error("port mask");
    int_out_a: assert property (int_out == |(global_int_status & global_int_mask))
        else $error("global mask");
    cover property (pkt_valid && pkt_hit);
    cover property ($rose(int_out));
    cover property (|(port_int_status & port_int_clear));
endmodule
bind acl_action_and_count_unit acl_action_props i_acl_action_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .pkt_valid(pkt_valid), .pkt_hit(pkt_hit), .qos_priority(qos_priority),
    .vlan_pcp(vlan_pcp), .lookup_map(lookup_map), .res_valid(res_valid),
    .res_priority(res_priority), .res_pcp(res_pcp), .res_map(res_map),
    .res_process(res_process), .port_int_mask(port_int_mask), .port_int_clear(port_int_clear),
    .global_int_mask(global_int_mask), .port_int_status(port_int_status),
    .global_int_status(global_int_status), .int_out(int_out));

// >>> bench/acl_action_and_count_unit_bench.sv
// Self-checking bench for the ACL action and count unit.
// Assumes the lookup model supplies packet fields after each falling edge.
`timescale 1ns/1ps
module acl_action_and_count_unit_bench;
    reg ref_clk, rst_n, tbl_wr, pkt_valid, pkt_hit;
    reg [2:0] tbl_port, pkt_port, q, v;
    reg [3:0] tbl_idx, pkt_idx;
    reg [1:0] tbl_match_layer_sel, tbl_match_variant_sel;
    reg [19:0] tbl_action;
    reg [7:0] tbl_process;
    reg [6:0] port_int_mask, port_int_clear, global_int_mask, m;
    wire [2:0] qos_priority, vlan_pcp, res_priority, res_pcp;
    wire [6:0] lookup_map, res_map, port_int_status, global_int_status;
    wire [7:0] res_process;
    wire res_valid, int_out;
    reg [31:0] r;
    integer seed, miscompares, compares, k, n;
    acl_lookup_model i_acl_lookup_model (.ref_clk(ref_clk), .qos_priority(qos_priority),
        .vlan_pcp(vlan_pcp), .lookup_map(lookup_map));
    acl_action_and_count_unit i_acl_action_and_count_unit (.ref_clk(ref_clk), .rst_n(rst_n),
        .tbl_wr(tbl_wr), .tbl_port(tbl_port), .tbl_idx(tbl_idx),
        .tbl_match_layer_sel(tbl_match_layer_sel), .tbl_match_variant_sel(tbl_match_variant_sel),
        .tbl_action(tbl_action), .tbl_process(tbl_process), .pkt_valid(pkt_valid),
        .pkt_port(pkt_port), .pkt_hit(pkt_hit), .pkt_idx(pkt_idx), .qos_priority(qos_priority),
        .vlan_pcp(vlan_pcp), .lookup_map(lookup_map), .res_valid(res_valid),
        .res_priority(res_priority), .res_pcp(res_pcp), .res_map(res_map),
        .res_process(res_process), .port_int_mask(port_int_mask),
        .port_int_clear(port_int_clear), .global_int_mask(global_int_mask),
        .port_int_status(port_int_status), .global_int_status(global_int_status),
        .int_out(int_out));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function [2:0] eprio(input [1:0] pm, input [2:0] rp, input [2:0] qp);
        case (pm)
            2'h0: eprio = qp;
            2'h1: eprio = (rp > qp) ? rp : qp;
            2'h2: eprio = (rp < qp) ? rp : qp;
            default: eprio = rp;
        endcase
    endfunction
    function [6:0] emap(input [1:0] mm, input [6:0] f, input [6:0] l);
        case (mm)
            2'h0: emap = l;
            2'h1: emap = l | f;
            2'h2: emap = l & f;
            default: emap = f;
        endcase
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [2:0] p, input [3:0] i, input [1:0] ls, input [1:0] vs, input [19:0] a,
        input [7:0] pr);
        begin
            @(negedge ref_clk);
            {tbl_wr, tbl_port, tbl_idx, tbl_match_layer_sel} = {1'h1, p, i, ls};
            {tbl_match_variant_sel, tbl_action, tbl_process} = {vs, a, pr};
            @(negedge ref_clk);
            tbl_wr = 1'h0;
        end
    endtask
    task pkt(input [2:0] p, input h, input [3:0] i);
        begin
            @(negedge ref_clk);
            {pkt_valid, pkt_port, pkt_hit, pkt_idx} = {1'h1, p, h, i};
            #1;
            {q, v, m} = {qos_priority, vlan_pcp, lookup_map};
            @(posedge ref_clk);
            #1;
            chk(res_valid, 1);
            @(negedge ref_clk);
            pkt_valid = 1'h0;
        end
    endtask
    task report_and_stop;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0) begin
                $display("All checks passed");
            end else begin
                $display("Checks failed");
            end
            $finish;
        end
    endtask
    initial begin
        {seed, miscompares, compares} = {32'd76636, 64'h0};
        {rst_n, tbl_wr, pkt_valid, pkt_hit, tbl_port, pkt_port, tbl_idx, pkt_idx} = 18'h0;
        {tbl_match_layer_sel, tbl_match_variant_sel, tbl_action, tbl_process} = 32'h0;
        {port_int_mask, port_int_clear, global_int_mask} = 21'h0;
        repeat (4) @(negedge ref_clk);
        rst_n = 1'h1;
        for (k = 0; k < 16; k = k + 1) begin
            r = $random(seed);
            n = k % 7;
            wr(n[2:0], k[3:0], 2'h2, r[31:30],
                {k[3:2], r[2:0], r[3], r[6:4], k[1:0], 2'h0, r[13:7]}, r[21:14]);
            pkt(n[2:0], 1'h1, k[3:0]);
            chk(res_priority, eprio(k[3:2], r[2:0], q));
            chk(res_pcp, r[3] ? r[6:4] : v);
            chk(res_map, emap(k[1:0], r[13:7], m));
            chk(res_process, r[21:14]);
        end
        chk(port_int_status, 0);
        $display("test filter actions done");
        {port_int_mask, global_int_mask} = {7'h08, 7'h08};
        wr(3, 5, 2'h1, 2'h0, {11'h003, 1'h0, 1'h1, 7'h00}, 8'h00);
        pkt(3, 1'h1, 5);
        chk({res_priority, res_map, res_process}, {q, m, 8'h00});
        pkt(3, 1'h0, 5);
        pkt(3, 1'h1, 5);
        chk(port_int_status, 0);
        pkt(3, 1'h1, 5);
        @(negedge ref_clk);
        chk(port_int_status, 7'h08);
        chk({global_int_status, int_out}, 8'h11);
        {global_int_mask, port_int_clear} = {7'h00, 7'h08};
        @(negedge ref_clk);
        port_int_clear = 7'h00;
        chk({port_int_status, int_out}, 0);
        pkt(3, 1'h1, 5);
        pkt(3, 1'h1, 5);
        @(negedge ref_clk);
        chk(port_int_status, 0);
        $display("test packet count done");
        wr(1, 2, 2'h1, 2'h0, {11'h002, 1'h0, 1'h0, 7'h00}, 8'h00);
        pkt(1, 1'h1, 2);
        repeat (150) @(negedge ref_clk);
        pkt(1, 1'h1, 2);
        repeat (190) @(negedge ref_clk);
        chk(port_int_status, 0);
        n = 0;
        while (port_int_status[1] !== 1'h1 && n < 200) begin
            @(negedge ref_clk);
            n = n + 1;
        end
        chk(n < 200, 1);
        chk({global_int_status, int_out}, 8'h00);
        $display("test timeout done");
        wr(2, 3, 2'h1, 2'h0, {11'h000, 1'h1, 1'h0, 7'h00}, 8'h00);
        pkt(2, 1'h1, 3);
        repeat (300) @(negedge ref_clk);
        chk(port_int_status[2], 0);
        $display("test millisecond unit done");
        report_and_stop;
    end
endmodule
